// ===== include/ccpm_pkg.sv
package ccpm_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CAPSEL = 8'h04;
	localparam logic [7:0] OFS_DUTY_LO = 8'h08;
	localparam logic [7:0] OFS_DUTY_HI = 8'h0C;
	localparam logic [7:0] OFS_FLAG = 8'h10;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [2:0] RST_CAPSEL = 3'h0;
	localparam logic [7:0] RST_DUTY = 8'h00;
	localparam int EN_BIT = 7;
	localparam int ZERO_BIT = 6;
	localparam int OUT_BIT = 5;
	localparam int FMT_BIT = 4;
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_TGL_CLR = 4'h1;
	localparam logic [3:0] MODE_TGL = 4'h2;
	localparam logic [3:0] MODE_CAP_ANY = 4'h3;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_4 = 4'h6;
	localparam logic [3:0] MODE_CAP_16 = 4'h7;
	localparam logic [3:0] MODE_SET = 4'h8;
	localparam logic [3:0] MODE_CLR = 4'h9;
	localparam logic [3:0] MODE_PULSE = 4'hA;
	localparam logic [3:0] MODE_PULSE_CLR = 4'hB;
	localparam logic [3:0] MODE_PWM = 4'hF;
	localparam logic [3:0] PRE4_LAST = 4'h3;
	localparam logic [3:0] PRE16_LAST = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== logic/ccpm_top.sv
`timescale 1ns/10ps
module ccpm_top import ccpm_pkg::*; #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] S_AWADDR,
	input wire logic S_AWVALID,
	output logic S_AWREADY,
	input wire logic [31:0] S_WDATA,
	input wire logic [3:0] S_WSTRB,
	input wire logic S_WVALID,
	output logic S_WREADY,
	output logic [1:0] S_BRESP,
	output logic S_BVALID,
	input wire logic S_BREADY,
	input wire logic [ADDR_W-1:0] S_ARADDR,
	input wire logic S_ARVALID,
	output logic S_ARREADY,
	output logic [31:0] S_RDATA,
	output logic [1:0] S_RRESP,
	output logic S_RVALID,
	input wire logic S_RREADY,
	// timers and system state
	input wire logic [7:0] PWM_TIMER_COUNT,
	input wire logic [7:0] PERIOD_LIMIT,
	input wire logic PWM_TIMER_INC,
	input wire logic PRESCALE_ONE,
	input wire logic [1:0] PRESCALE_BITS,
	input wire logic [15:0] COMPARE_TIMER,
	input wire logic SLEEP,
	input wire logic ADC_SOURCE_SEL,
	// capture sources, asynchronous
	input wire logic REMAPPED_INPUT_PIN,
	input wire logic COMPARATOR_ONE_OUTPUT,
	input wire logic COMPARATOR_TWO_OUTPUT,
	input wire logic PIN_CHANGE_EVENT,
	input wire logic [3:0] LOGIC_CELL_OUTPUT,
	// module outputs
	output logic MODULE_OUT,
	output logic MODULE_OUT_OE,
	output logic MODULE_INTERRUPT_FLAG,
	output logic ADC_TRIGGER,
	output logic COMPARE_TIMER_CLEAR
);
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [7:0] ctrl_r;
	logic [2:0] capsel_r;
	logic [7:0] duty_lo_r;
	logic [7:0] duty_hi_r;
	logic flag_r;
	logic [9:0] dbuf_r;
	logic out_r;
	logic oe_r;
	logic adc_r;
	logic tclr_r;
	logic pulse_r;
	logic match_d_r;
	logic set_d_r;
	logic [1:0] phase_r;
	logic [3:0] pre_r;
	logic [7:0] src_s1_r;
	logic [7:0] src_s2_r;
	logic src_prev_r;
	logic awr_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic arr_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [31:0] rdata_r;

	// reset release through two flops
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// capture sources are asynchronous, two flops before use
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			src_s1_r <= 8'h00;
			src_s2_r <= 8'h00;
		end else begin
			src_s1_r <= {LOGIC_CELL_OUTPUT, PIN_CHANGE_EVENT, COMPARATOR_TWO_OUTPUT,
				COMPARATOR_ONE_OUTPUT, REMAPPED_INPUT_PIN};
			src_s2_r <= src_s1_r;
		end
	end

	// control field decode
	wire en = ctrl_r[EN_BIT];
	wire fmt = ctrl_r[FMT_BIT];
	wire [3:0] mode = ctrl_r[3:0];
	wire act = en & ~SLEEP;
	wire is_pwm = mode == MODE_PWM;
	wire is_off = mode == MODE_OFF;
	wire is_cap = (mode >= MODE_CAP_ANY) && (mode <= MODE_CAP_16);
	wire is_cmp = (mode == MODE_TGL) || (mode == MODE_TGL_CLR) || ((mode >= MODE_SET) && (mode <= MODE_PULSE_CLR));

	// duty assembly: format only matters in pwm mode
	wire [9:0] duty_right = {duty_hi_r[1:0], duty_lo_r};
	wire [9:0] duty_left = {duty_hi_r, duty_lo_r[7:6]};
	wire [9:0] duty_val = fmt ? duty_left : duty_right;

	// 10-bit time base; phase counter tracks clocks between timer ticks
	wire [1:0] low2 = PRESCALE_ONE ? phase_r : PRESCALE_BITS;
	wire [9:0] tbase = {PWM_TIMER_COUNT, low2};
	wire [9:0] tlimit = {PERIOD_LIMIT, 2'h3};
	wire roll = act & is_pwm & PWM_TIMER_INC & (PWM_TIMER_COUNT == PERIOD_LIMIT);
	// a duty above the period never matches, so the pin is left alone
	wire pwm_clr = act & is_pwm & (tbase == dbuf_r) & (dbuf_r <= tlimit);

	// compare: act on the first cycle of a match only
	wire match = {duty_hi_r, duty_lo_r} == COMPARE_TIMER;
	wire cmp_hit = act & is_cmp & match & ~match_d_r;

	// capture source select and edge shaping
	wire src_sel = src_s2_r[capsel_r];
	wire rise = src_sel & ~src_prev_r;
	wire fall = ~src_sel & src_prev_r;
	wire pre_last = (mode == MODE_CAP_4) ? (pre_r == PRE4_LAST) : (pre_r == PRE16_LAST);
	wire cap_any = (mode == MODE_CAP_ANY) & (rise | fall);
	wire cap_fall = (mode == MODE_CAP_FALL) & fall;
	wire cap_rise = (mode == MODE_CAP_RISE) & rise;
	wire cap_pre = ((mode == MODE_CAP_4) | (mode == MODE_CAP_16)) & rise & pre_last;
	wire cap_hit = act & is_cap & (cap_any | cap_fall | cap_rise | cap_pre);

	// every mode's event feeds the flag and adc trigger
	wire event_hit = cap_hit | cmp_hit | roll;
	wire tclr_hit = cmp_hit & ((mode == MODE_PULSE_CLR) | (mode == MODE_TGL_CLR));

	// output level next value
	logic out_nxt;
	always_comb begin
		out_nxt = out_r;
		if (!en || is_off) begin
			out_nxt = 1'b0;
		end else if (SLEEP) begin
			out_nxt = out_r;
		end else if (is_pwm) begin
			// set lags the roll by one clock, as the clear does, so high time is exactly the duty
			if (set_d_r) begin
				out_nxt = dbuf_r != 10'h000;
			end else if (pwm_clr) begin
				out_nxt = 1'b0;
			end
		end else if (pulse_r) begin
			out_nxt = 1'b0;
		end else if (cmp_hit) begin
			case (mode)
				MODE_SET: out_nxt = 1'b1;
				MODE_CLR: out_nxt = 1'b0;
				MODE_PULSE, MODE_PULSE_CLR: out_nxt = 1'b1;
				MODE_TGL, MODE_TGL_CLR: out_nxt = ~out_r;
				default: out_nxt = out_r;
			endcase
		end
	end

	// core state; sleep freezes the waveform state, but oe_r still follows en and a disable still clears it
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			out_r <= 1'b0;
			oe_r <= 1'b0;
			dbuf_r <= 10'h000;
			set_d_r <= 1'b0;
			pulse_r <= 1'b0;
			match_d_r <= 1'b0;
			phase_r <= 2'h0;
			pre_r <= 4'h0;
			src_prev_r <= 1'b0;
			adc_r <= 1'b0;
			tclr_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
			oe_r <= en;
			adc_r <= event_hit & ADC_SOURCE_SEL;
			tclr_r <= tclr_hit;
			if (!en || is_off) begin
				dbuf_r <= 10'h000;
				set_d_r <= 1'b0;
				pulse_r <= 1'b0;
				match_d_r <= 1'b0;
				phase_r <= 2'h0;
				pre_r <= 4'h0;
				src_prev_r <= src_sel;
			end else if (!SLEEP) begin
				if (roll) begin
					dbuf_r <= duty_val;
				end
				set_d_r <= roll;
				pulse_r <= cmp_hit & ((mode == MODE_PULSE) | (mode == MODE_PULSE_CLR));
				match_d_r <= match;
				phase_r <= PWM_TIMER_INC ? 2'h0 : phase_r + 2'h1;
				if (is_cap & rise & ((mode == MODE_CAP_4) | (mode == MODE_CAP_16))) begin
					pre_r <= pre_last ? 4'h0 : pre_r + 4'h1;
				end
				src_prev_r <= src_sel;
			end
		end
	end

	// axi decode
	wire aw_go = S_AWVALID & S_WVALID & ~awr_r & ~bvalid_r;
	wire ar_go = S_ARVALID & ~arr_r & ~rvalid_r;
	wire [7:0] waddr = 8'(S_AWADDR);
	wire [7:0] raddr = 8'(S_ARADDR);
	wire wr_lane = aw_go & S_WSTRB[0];
	wire wr_ctrl = wr_lane & (waddr == OFS_CTRL);
	wire wr_capsel = wr_lane & (waddr == OFS_CAPSEL);
	wire wr_lo = wr_lane & (waddr == OFS_DUTY_LO);
	wire wr_hi = wr_lane & (waddr == OFS_DUTY_HI);
	wire wr_flag = wr_lane & (waddr == OFS_FLAG);
	wire w_map = (waddr == OFS_CTRL) | (waddr == OFS_CAPSEL) | (waddr == OFS_DUTY_LO) |
		(waddr == OFS_DUTY_HI) | (waddr == OFS_FLAG);
	wire [7:0] ctrl_rd = {ctrl_r[7], 1'b0, out_r, ctrl_r[4:0]};
	wire r_map = (raddr == OFS_CTRL) | (raddr == OFS_CAPSEL) | (raddr == OFS_DUTY_LO) |
		(raddr == OFS_DUTY_HI) | (raddr == OFS_FLAG);
	wire [7:0] rd_byte = (raddr == OFS_CTRL) ? ctrl_rd :
		(raddr == OFS_CAPSEL) ? {5'h00, capsel_r} :
		(raddr == OFS_DUTY_LO) ? duty_lo_r :
		(raddr == OFS_DUTY_HI) ? duty_hi_r :
		(raddr == OFS_FLAG) ? {7'h00, flag_r} : 8'h00;

	// software registers; capture loads the duty pair and beats a write
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= RST_CTRL;
			capsel_r <= RST_CAPSEL;
			duty_lo_r <= RST_DUTY;
			duty_hi_r <= RST_DUTY;
			flag_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= {S_WDATA[7], 1'b0, 1'b0, S_WDATA[4:0]};
			end
			if (wr_capsel) begin
				capsel_r <= S_WDATA[2:0];
			end
			if (cap_hit) begin
				duty_lo_r <= COMPARE_TIMER[7:0];
				duty_hi_r <= COMPARE_TIMER[15:8];
			end else begin
				if (wr_lo) begin
					duty_lo_r <= S_WDATA[7:0];
				end
				if (wr_hi) begin
					duty_hi_r <= S_WDATA[7:0];
				end
			end
			// a new event wins over a write-one clear
			if (event_hit) begin
				flag_r <= 1'b1;
			end else if (wr_flag & S_WDATA[0]) begin
				flag_r <= 1'b0;
			end
		end
	end

	// axi handshakes: one write and one read at a time
	always_ff @(posedge CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			awr_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			arr_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			awr_r <= aw_go;
			if (aw_go) begin
				bvalid_r <= 1'b1;
				bresp_r <= w_map ? RESP_OKAY : RESP_SLVERR;
			end else if (S_BREADY) begin
				bvalid_r <= 1'b0;
			end
			arr_r <= ar_go;
			if (ar_go) begin
				rvalid_r <= 1'b1;
				rresp_r <= r_map ? RESP_OKAY : RESP_SLVERR;
				rdata_r <= {24'h000000, rd_byte};
			end else if (S_RREADY) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	assign S_AWREADY = awr_r;
	assign S_WREADY = awr_r;
	assign S_BVALID = bvalid_r;
	assign S_BRESP = bresp_r;
	assign S_ARREADY = arr_r;
	assign S_RVALID = rvalid_r;
	assign S_RRESP = rresp_r;
	assign S_RDATA = rdata_r;
	assign MODULE_OUT = out_r;
	assign MODULE_OUT_OE = oe_r;
	assign MODULE_INTERRUPT_FLAG = flag_r;
	assign ADC_TRIGGER = adc_r;
	assign COMPARE_TIMER_CLEAR = tclr_r;

	// checks on the driven side
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!rst_n);

	a_pwm_clear_low: assert property (pwm_clr & ~roll & en & ~is_off |=> !out_r)
		else $error("pwm output not cleared at duty match");
	a_buf_load: assert property (roll & ~is_off |=> dbuf_r == $past(duty_val))
		else $error("duty buffer not loaded at period roll");
	a_roll_set: assert property (set_d_r & act & is_pwm |=> out_r == ($past(dbuf_r) != 10'h000))
		else $error("output wrong after period roll");
	a_off_low: assert property (!en |=> !out_r && !adc_r && !tclr_r)
		else $error("disabled module not quiet");
	a_sleep_hold: assert property (en & SLEEP & ~is_off |=> $stable(out_r) && $stable(dbuf_r))
		else $error("state changed during sleep");
	a_ctrl_read: assert property (ar_go & (raddr == OFS_CTRL) |=>
		S_RDATA[ZERO_BIT] == 1'b0 && S_RDATA[OUT_BIT] == $past(out_r))
		else $error("control read shows wrong bits");
	a_adc_pulse: assert property (event_hit & ADC_SOURCE_SEL |=>
		adc_r ##1 (adc_r == ($past(event_hit) & $past(ADC_SOURCE_SEL))))
		else $error("adc trigger not pulsed for event");
	a_tclr_pulse: assert property (cmp_hit & (mode == MODE_PULSE_CLR) |=> tclr_r ##1 !out_r)
		else $error("pulse and timer clear missing");
	a_toggle_out: assert property (cmp_hit & (mode == MODE_TGL) & ~pulse_r |=> out_r != $past(out_r))
		else $error("toggle mode did not toggle");
	a_capsel_read: assert property (ar_go & (raddr == OFS_CAPSEL) |=> S_RDATA[7:3] == 5'h00)
		else $error("capture source upper bits not zero");
endmodule

// ===== tb/ccpm_tmr_model.sv
`timescale 1ns/10ps
module ccpm_tmr_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// control from the bench
	input wire logic [7:0] period,
	input wire logic sleep,
	input wire logic run,
	input wire logic clr,
	// timer values
	output logic [7:0] count,
	output logic inc,
	output logic [15:0] cmp
);
	logic [1:0] pre_r;
	// prescale of four so the 1:1 phase counter covers all four steps
	assign inc = (pre_r == 2'h3) && !sleep;
	// pwm timer wraps after the period limit; sleep holds its count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_r <= 2'h0;
			count <= 8'h00;
		end else if (!sleep) begin
			pre_r <= pre_r + 2'h1;
			if (inc) begin
				count <= (count == period) ? 8'h00 : count + 8'h01;
			end
		end
	end
	// compare timer, cleared by the module or by the bench
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmp <= 16'h0000;
		end else if (clr) begin
			cmp <= 16'h0000;
		end else if (run) begin
			cmp <= cmp + 16'h0001;
		end
	end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench import ccpm_pkg::*;;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	logic sleep = 1'b0, adc_sel = 1'b1, run = 1'b0, tclr = 1'b0, pre_one = 1'b1;
	logic [7:0] src = 8'h00;
	logic awready, wready, bvalid, arready, rvalid, inc, mout, moe, flag, adc, cclr;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] count;
	logic [15:0] cmp;
	int miscompares = 0, total_checks = 0, cyc = 0, hi_n = 0, adc_n = 0, clr_n = 0;
	int i, b0, b1, b2;
	logic [3:0] cm [6] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'h2, 4'h1};
	logic ce [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic [7:0] ph [4] = '{8'h00, 8'h01, 8'h00, 8'h03};
	logic [7:0] pl [4] = '{8'h06, 8'h80, 8'h00, 8'hFF};
	logic [31:0] pc [4] = '{32'h8F, 32'h9F, 32'h8F, 32'h8F};
	int pe [4] = '{6, 6, 0, 16};

	always #12.5 clk = ~clk;

	ccpm_top uut (
		.CLK_SYS(clk), .RST_B(rst_b),
		.S_AWADDR(awaddr), .S_AWVALID(awv), .S_AWREADY(awready), .S_WDATA(wdata), .S_WSTRB(wstrb),
		.S_WVALID(wv), .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid), .S_BREADY(bready),
		.S_ARADDR(araddr), .S_ARVALID(arv), .S_ARREADY(arready), .S_RDATA(rdata), .S_RRESP(rresp),
		.S_RVALID(rvalid), .S_RREADY(rready),
		.PWM_TIMER_COUNT(count), .PERIOD_LIMIT(8'h03), .PWM_TIMER_INC(inc), .PRESCALE_ONE(pre_one),
		.PRESCALE_BITS(2'h2), .COMPARE_TIMER(cmp), .SLEEP(sleep), .ADC_SOURCE_SEL(adc_sel),
		.REMAPPED_INPUT_PIN(src[0]), .COMPARATOR_ONE_OUTPUT(src[1]), .COMPARATOR_TWO_OUTPUT(src[2]),
		.PIN_CHANGE_EVENT(src[3]), .LOGIC_CELL_OUTPUT(src[7:4]),
		.MODULE_OUT(mout), .MODULE_OUT_OE(moe), .MODULE_INTERRUPT_FLAG(flag), .ADC_TRIGGER(adc),
		.COMPARE_TIMER_CLEAR(cclr)
	);

	ccpm_tmr_model tmr (.clk(clk), .rst_b(rst_b), .period(8'h03), .sleep(sleep), .run(run),
		.clr(cclr | tclr), .count(count), .inc(inc), .cmp(cmp));

	// running tallies; tests read differences so no reset race
	always @(posedge clk) begin
		cyc <= cyc + 1;
		hi_n <= hi_n + ((mout === 1'b1) ? 1 : 0);
		adc_n <= adc_n + ((adc === 1'b1) ? 1 : 0);
		clr_n <= clr_n + ((cclr === 1'b1) ? 1 : 0);
		if (cyc >= 20000) begin
			miscompares = miscompares + 1;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// write: address and data offered together, held until both readies
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk); while (!(awready === 1'b1 && wready === 1'b1));
		awv <= 1'b0;
		wv <= 1'b0;
		while (bvalid !== 1'b1) @(posedge clk);
		bready <= 1'b0;
		chk(bresp, er);
		@(posedge clk);
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arv <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		rready <= 1'b0;
		chk(rdata, ed);
		chk(rresp, er);
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axw(a, d, 4'h1, RESP_OKAY);
	endtask

	// one high-low pulse on a capture source, slow enough for the sync flops
	task automatic pulse(input int k);
		src[k] <= 1'b1;
		tick(4);
		src[k] <= 1'b0;
		tick(4);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		tick(5);
		rst_b <= 1'b1;
		tick(3);
		chk(moe, 1'b0);
		axr(OFS_CTRL, RST_CTRL, RESP_OKAY);
		axr(OFS_CAPSEL, RST_CAPSEL, RESP_OKAY);
		axr(OFS_DUTY_HI, RST_DUTY, RESP_OKAY);
		axr(8'h14, 32'h0, RESP_SLVERR);
		axw(8'h14, 32'hFF, 4'hF, RESP_SLVERR);
		wr(OFS_CAPSEL, 32'hFF);
		axr(OFS_CAPSEL, 32'h07, RESP_OKAY);
		axw(OFS_CAPSEL, 32'h00, 4'h0, RESP_OKAY);
		axr(OFS_CAPSEL, 32'h07, RESP_OKAY);
		// compare modes: match at 0x0010, timer stopped shortly after
		wr(OFS_DUTY_LO, 32'h10);
		wr(OFS_DUTY_HI, 32'h00);
		for (i = 0; i < 6; i++) begin
			wr(OFS_CTRL, 32'h80);
			wr(OFS_FLAG, 32'h01);
			chk(mout, 1'b0);
			b0 = hi_n;
			b1 = adc_n;
			b2 = clr_n;
			wr(OFS_CTRL, {24'h0, 4'h8, cm[i]});
			run <= 1'b1;
			while (flag !== 1'b1) @(posedge clk);
			tick(3);
			run <= 1'b0;
			tclr <= 1'b1;
			chk(mout, ce[i]);
			chk(adc_n - b1, 1);
			chk(clr_n - b2, (cm[i] == 4'hB || cm[i] == 4'h1));
			if (cm[i] == 4'hA || cm[i] == 4'hB) chk(hi_n - b0, 1);
			tick(1);
			tclr <= 1'b0;
		end
		// capture: each source alone must trigger, the wrong one must not
		run <= 1'b1;
		tick(37);
		run <= 1'b0;
		adc_sel <= 1'b0;
		b1 = adc_n;
		for (i = 0; i < 8; i++) begin
			wr(OFS_CTRL, 32'h00);
			wr(OFS_FLAG, 32'h01);
			wr(OFS_CAPSEL, i);
			wr(OFS_CTRL, 32'h85);
			pulse((i + 1) % 8);
			chk(flag, 1'b0);
			pulse(i);
			chk(flag, 1'b1);
		end
		chk(adc_n - b1, 0);
		axr(OFS_DUTY_LO, {24'h0, cmp[7:0]}, RESP_OKAY);
		axr(OFS_DUTY_HI, {24'h0, cmp[15:8]}, RESP_OKAY);
		wr(OFS_CAPSEL, 32'h00);
		for (i = 0; i < 2; i++) begin
			wr(OFS_CTRL, 32'h00);
			wr(OFS_FLAG, 32'h01);
			wr(OFS_CTRL, 32'h86 + i);
			repeat (3 + 12 * i) pulse(0);
			chk(flag, 1'b0);
			pulse(0);
			chk(flag, 1'b1);
		end
		// pwm with period 3: sixteen clocks a period, high time = duty, or the whole period for a duty above the period
		for (i = 0; i < 4; i++) begin
			wr(OFS_DUTY_HI, ph[i]);
			wr(OFS_DUTY_LO, pl[i]);
			wr(OFS_CTRL, pc[i]);
			tick(40);
			b0 = hi_n;
			tick(16);
			chk(hi_n - b0, pe[i]);
		end
		chk(moe, 1'b1);
		wr(OFS_CTRL, 32'hEF);
		axr(OFS_CTRL, 32'hAF, RESP_OKAY);
		// sleep holds the level, wake resumes the waveform
		wr(OFS_DUTY_HI, 32'h00);
		wr(OFS_DUTY_LO, 32'h06);
		tick(40);
		sleep <= 1'b1;
		tick(2);
		b1 = (mout === 1'b1) ? 1 : 0;
		b0 = hi_n;
		tick(32);
		chk(hi_n - b0, b1 * 32);
		sleep <= 1'b0;
		tick(40);
		b0 = hi_n;
		tick(16);
		chk(hi_n - b0, 6);
		// prescaler bits held at 2: time base steps 2,6,10,14, so duty 6 clears after four clocks
		pre_one <= 1'b0;
		tick(40);
		b0 = hi_n;
		tick(16);
		chk(hi_n - b0, 4);
		pre_one <= 1'b1;
		// disabled before the clear, so a late period event cannot leave the flag set
		wr(OFS_CTRL, 32'h7F);
		wr(OFS_FLAG, 32'h01);
		axr(OFS_CTRL, 32'h1F, RESP_OKAY);
		b0 = hi_n;
		tick(40);
		chk(hi_n - b0, 0);
		chk(flag, 1'b0);
		chk(moe, 1'b0);
		test_done();
	end
endmodule
